// ==== src/hap_params.svh ====
// Constants for the Hall-array position controller
`ifndef HAP_PARAMS_SVH
`define HAP_PARAMS_SVH
// How it works
// - Sensor config register 2h arms conversion on falling trigger edge.
// - Bit 8 of that register selects the special two-channel 32-bit frame.
// - Trigger pulse is active low, 100ns wide, repeated at 4 kHz.
// - After conversion the four sensors are read in turn, own chip select.
// - Readout starts 57.5us after sample instant, finishes within 15us.
// - Linear position is recomputed once per sample period.
// - No Z magnitude above threshold: out of range, zero outputs.
// - Otherwise pick sensor with largest Z magnitude, compute for it only.
// - Hysteresis on the strongest-sensor choice avoids toggling.
// - Selected Z minus per-sensor offset, then times per-sensor gain.
// - Angle is atan2 of corrected Z and raw X, in units where 90 degrees = 2^14.
// - Position is angle/90 times 1.25cm plus index times 2.5cm minus offset.
// - Add absolute X times off-axis gain to the position.
// - Selection code 0 out of range, 3,5,7,9 for sensors 0..3.
// - Position error is position minus captured reference position.
// - Serial clock 10MHz idle low, two 16-bit halves, launch fall.

// Timing in ns and Hz, cycle counts derived
`define HAP_CLK_NS 4
`define HAP_TRIG_NS 100
`define HAP_SAMPLE_HZ 4000
`define HAP_EFF_SAMPLE_NS 47500
`define HAP_READ_DELAY_NS 57500
`define HAP_READ_BUDGET_NS 15000
`define HAP_SCLK_HZ 10000000
`define HAP_TRIG_CYC ((`HAP_TRIG_NS + `HAP_CLK_NS - 1) / `HAP_CLK_NS)
`define HAP_PERIOD_CYC (1000000000 / (`HAP_SAMPLE_HZ * `HAP_CLK_NS))
`define HAP_CONV_WAIT_CYC ((`HAP_EFF_SAMPLE_NS + `HAP_READ_DELAY_NS \
  + `HAP_CLK_NS - 1) / `HAP_CLK_NS)
`define HAP_READ_BUDGET_CYC (`HAP_READ_BUDGET_NS / `HAP_CLK_NS)
`define HAP_SCLK_HALF_CYC \
  ((1000000000 / `HAP_SCLK_HZ / 2 + `HAP_CLK_NS - 1) / `HAP_CLK_NS)
`define HAP_FRAME_BITS 32
`define HAP_HALF_BITS 16
// Sensor side: config register 2h word
`define HAP_SNS_CFG2_ADDR 7'h02
`define HAP_SNS_TRIG_ALERT 16'h0400
`define HAP_SNS_SPECIAL 16'h0100
`define HAP_SNS_WR_CMD 8'h00
// Special frame layout: status, Z, X, crc
`define HAP_FR_Z 27:16
`define HAP_FR_X 15:4
// Fixed point scaling
`define HAP_GAIN_FRAC 12
`define HAP_ANG_Q_LOG2 14
`define HAP_OFFAXIS_FRAC 8
`define HAP_SPACING_UM 25000
`define HAP_GAIN_ONE 16'h1000
// Register map of the controller
`define HAP_RA_CTRL 5'h00
`define HAP_RA_STATUS 5'h01
`define HAP_RA_THRESH 5'h02
`define HAP_RA_HYST 5'h03
`define HAP_RA_BASE 5'h04
`define HAP_RA_OFFAXIS 5'h05
`define HAP_RA_POS 5'h06
`define HAP_RA_ERR 5'h07
`define HAP_RA_ANGLE 5'h08
`define HAP_RA_CFGWORD 5'h09
`define HAP_RA_RDWORD 5'h0A
`define HAP_RA_ZOFF 5'h10
`define HAP_RA_GAIN 5'h14
`define HAP_RA_FRAME 5'h18
`endif

// ==== src/hap_pkg.sv ====
// Types for the Hall-array position controller
package hap_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_TRIG = 4'h1,
    ST_CONV = 4'h2,
    ST_CSGAP = 4'h3,
    ST_XFER = 4'h4,
    ST_SEL = 4'h5,
    ST_ZCORR = 4'h6,
    ST_ANGLE = 4'h7,
    ST_POS = 4'h8,
    ST_OUT = 4'h9
  } hap_state_t;
  typedef logic signed [11:0] hap_field_t;
endpackage : hap_pkg

// ==== src/hap_spi.sv ====
// SPI frame engine: idle-low clock, 32 bits as two 16-bit halves
`timescale 1ns/1ps
`include "hap_params.svh"
module hap_spi #(
  parameter int unsigned HALF_CYC = `HAP_SCLK_HALF_CYC,
  parameter int unsigned BITS = `HAP_FRAME_BITS,
  parameter int unsigned SPLIT = `HAP_HALF_BITS
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [BITS-1:0] tx_word,
  input wire logic miso_s,
  output logic sclk_q,
  output logic mosi_q,
  output logic busy_q,
  output logic done_q,
  output logic [BITS-1:0] rx_q
);
  logic [15:0] div_q;
  logic tick;
  logic gap_q;
  logic [5:0] bit_q;
  logic [BITS-1:0] tx_q;

  // Half-period enable for the serial clock
  assign tick = (div_q == 16'(HALF_CYC - 1));
  always_ff @(posedge mclk) begin
    if (!rst_n || !busy_q || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  // Launch on falling edge, sample on rising, idle low
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sclk_q <= 1'b0;
      mosi_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      gap_q <= 1'b0;
      bit_q <= '0;
      tx_q <= '0;
      rx_q <= '0;
    end else begin
      done_q <= 1'b0;
      if (start && !busy_q) begin
        busy_q <= 1'b1;
        mosi_q <= tx_word[BITS-1];
        tx_q <= tx_word << 1;
        bit_q <= '0;
        gap_q <= 1'b0;
      end else if (busy_q && tick) begin
        if (gap_q) begin
          gap_q <= 1'b0; // Idle half period between halves
        end else if (!sclk_q) begin
          sclk_q <= 1'b1;
          rx_q <= {rx_q[BITS-2:0], miso_s};
        end else begin
          sclk_q <= 1'b0;
          if (bit_q == 6'(BITS - 1)) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end else begin
            bit_q <= bit_q + 6'h01;
            mosi_q <= tx_q[BITS-1];
            tx_q <= tx_q << 1;
            gap_q <= (bit_q == 6'(SPLIT - 1));
          end
        end
      end
    end
  end
endmodule : hap_spi

// ==== src/hap_cordic.sv ====
// Vectoring rotation core: angle of (x, y), 90 degrees = 2^14
`timescale 1ns/1ps
`include "hap_params.svh"
module hap_cordic #(
  parameter int unsigned W = 18,
  parameter int unsigned AW = 18,
  parameter int unsigned ITER = 14
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic signed [W-1:0] x_in,
  input wire logic signed [W-1:0] y_in,
  output logic signed [AW-1:0] angle_q,
  output logic done_q
);
  localparam logic signed [AW-1:0] QUARTER = AW'(1) <<< `HAP_ANG_Q_LOG2;
  logic signed [W+1:0] x_q;
  logic signed [W+1:0] y_q;
  logic [3:0] it_q;
  logic busy_q;

  // Arctangent of 2^-i in the same angle units
  function automatic logic signed [AW-1:0] atan_lut(input logic [3:0] i);
    case (i)
      4'h0: atan_lut = AW'(18'h0_2000);
      4'h1: atan_lut = AW'(18'h0_12E4);
      4'h2: atan_lut = AW'(18'h0_09FB);
      4'h3: atan_lut = AW'(18'h0_0511);
      4'h4: atan_lut = AW'(18'h0_028B);
      4'h5: atan_lut = AW'(18'h0_0146);
      4'h6: atan_lut = AW'(18'h0_00A3);
      4'h7: atan_lut = AW'(18'h0_0051);
      4'h8: atan_lut = AW'(18'h0_0029);
      4'h9: atan_lut = AW'(18'h0_0014);
      4'hA: atan_lut = AW'(18'h0_000A);
      4'hB: atan_lut = AW'(18'h0_0005);
      4'hC: atan_lut = AW'(18'h0_0003);
      default: atan_lut = AW'(18'h0_0001);
    endcase
  endfunction : atan_lut

  // One micro-rotation per cycle; pre-rotation covers the left half plane
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      x_q <= '0;
      y_q <= '0;
      angle_q <= '0;
      it_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        busy_q <= 1'b1;
        it_q <= '0;
        if (x_in >= 0) begin
          x_q <= (W+2)'(x_in);
          y_q <= (W+2)'(y_in);
          angle_q <= '0;
        end else if (y_in >= 0) begin
          x_q <= (W+2)'(y_in);
          y_q <= -(W+2)'(x_in);
          angle_q <= QUARTER;
        end else begin
          x_q <= -(W+2)'(y_in);
          y_q <= (W+2)'(x_in);
          angle_q <= -QUARTER;
        end
      end else if (busy_q) begin
        // An on-axis vector is exact; further steps would only add dither
        if (y_q > 0) begin
          x_q <= x_q + (y_q >>> it_q);
          y_q <= y_q - (x_q >>> it_q);
          angle_q <= angle_q + atan_lut(it_q);
        end else if (y_q < 0) begin
          x_q <= x_q - (y_q >>> it_q);
          y_q <= y_q + (x_q >>> it_q);
          angle_q <= angle_q - atan_lut(it_q);
        end
        if (it_q == 4'(ITER - 1)) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
        it_q <= it_q + 4'h1;
      end
    end
  end
endmodule : hap_cordic

// ==== src/hap_top.sv ====
// Hall-array controller: trigger, four-sensor readout, position compute
`timescale 1ns/1ps
`include "hap_params.svh"
module hap_top #(
  parameter int unsigned PERIOD_CYC = `HAP_PERIOD_CYC,
  parameter int unsigned CONV_WAIT_CYC = `HAP_CONV_WAIT_CYC,
  parameter int unsigned SPACING_UM = `HAP_SPACING_UM
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [31:0] ref_pos,
  input wire logic sensor_serial_out,
  output logic spi_sclk,
  output logic spi_mosi,
  output logic [3:0] spi_cs_n,
  output logic conv_trigger_n,
  output logic [31:0] position,
  output logic [31:0] pos_error,
  output logic out_of_range,
  output logic [3:0] sel_code,
  output logic pos_valid
);
  localparam int unsigned NS = 4;
  localparam int unsigned HALF_SP = SPACING_UM / 2;

  hap_pkg::hap_state_t st_q;
  logic so1_q, so2_q;
  logic run_q, cfg_go_q, cfg_mode_q, cfg_done_q, late_q;
  logic [15:0] thresh_q, hyst_q, offaxis_q;
  logic [31:0] base_q, cfg_word_q, rd_word_q;
  logic [15:0] zoff_q [NS];
  logic [15:0] gain_q [NS];
  logic [31:0] frame_q [NS];
  logic [31:0] per_q, tmr_q, rd_tmr_q, ref_q, pos_calc_q;
  logic [1:0] sidx_q, num_q, max_n, pick_n;
  logic sel_valid_q;
  logic signed [17:0] zc_q, angle;
  logic spi_start_q, spi_busy, spi_done, cordic_start_q, cordic_done;
  logic [31:0] spi_rx;
  logic [15:0] absz [NS];
  logic signed [15:0] xsel;
  logic period_hit;

  // Pin input from the sensor bus passes two flops first
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      so1_q <= 1'b0;
      so2_q <= 1'b0;
    end else begin
      so1_q <= sensor_serial_out;
      so2_q <= so1_q;
    end
  end

  // Software registers; late flag set wins over clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      run_q <= 1'b0;
      cfg_go_q <= 1'b0;
      late_q <= 1'b0;
      thresh_q <= '0;
      hyst_q <= '0;
      offaxis_q <= '0;
      base_q <= '0;
      cfg_word_q <= {1'b0, `HAP_SNS_CFG2_ADDR,
                     `HAP_SNS_TRIG_ALERT | `HAP_SNS_SPECIAL,
                     `HAP_SNS_WR_CMD};
      rd_word_q <= '0;
      for (int i = 0; i < NS; i++) begin
        zoff_q[i] <= '0;
        gain_q[i] <= `HAP_GAIN_ONE;
      end
    end else begin
      cfg_go_q <= 1'b0;
      if (reg_wr) begin
        unique case (reg_addr)
          `HAP_RA_CTRL: begin
            run_q <= reg_wdata[0];
            cfg_go_q <= reg_wdata[1];
            if (reg_wdata[2]) begin
              late_q <= 1'b0;
            end
          end
          `HAP_RA_THRESH: thresh_q <= reg_wdata[15:0];
          `HAP_RA_HYST: hyst_q <= reg_wdata[15:0];
          `HAP_RA_BASE: base_q <= reg_wdata;
          `HAP_RA_OFFAXIS: offaxis_q <= reg_wdata[15:0];
          `HAP_RA_CFGWORD: cfg_word_q <= reg_wdata;
          `HAP_RA_RDWORD: rd_word_q <= reg_wdata;
          default: begin
            if (reg_addr[4:2] == `HAP_RA_ZOFF >> 2) begin
              zoff_q[reg_addr[1:0]] <= reg_wdata[15:0];
            end
            if (reg_addr[4:2] == `HAP_RA_GAIN >> 2) begin
              gain_q[reg_addr[1:0]] <= reg_wdata[15:0];
            end
          end
        endcase
      end
      // Readout overran its time budget
      if (st_q == hap_pkg::ST_XFER && spi_done && sidx_q == 2'(NS - 1)
          && !cfg_mode_q && rd_tmr_q > 32'(`HAP_READ_BUDGET_CYC)) begin
        late_q <= 1'b1;
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!rst_n || !reg_rd) begin
      reg_rdata <= '0;
    end else begin
      unique case (reg_addr)
        `HAP_RA_CTRL: reg_rdata <= {31'h0000_0000, run_q};
        `HAP_RA_STATUS: reg_rdata <= {20'h0_0000, sel_code, 4'h0,
          late_q, cfg_done_q, out_of_range, st_q != hap_pkg::ST_IDLE};
        `HAP_RA_THRESH: reg_rdata <= {16'h0000, thresh_q};
        `HAP_RA_HYST: reg_rdata <= {16'h0000, hyst_q};
        `HAP_RA_BASE: reg_rdata <= base_q;
        `HAP_RA_OFFAXIS: reg_rdata <= {16'h0000, offaxis_q};
        `HAP_RA_POS: reg_rdata <= position;
        `HAP_RA_ERR: reg_rdata <= pos_error;
        `HAP_RA_ANGLE: reg_rdata <= 32'(angle);
        `HAP_RA_CFGWORD: reg_rdata <= cfg_word_q;
        `HAP_RA_RDWORD: reg_rdata <= rd_word_q;
        default: begin
          unique case (reg_addr[4:2])
            3'(`HAP_RA_ZOFF >> 2):
              reg_rdata <= {16'h0000, zoff_q[reg_addr[1:0]]};
            3'(`HAP_RA_GAIN >> 2):
              reg_rdata <= {16'h0000, gain_q[reg_addr[1:0]]};
            3'(`HAP_RA_FRAME >> 2): reg_rdata <= frame_q[reg_addr[1:0]];
            default: reg_rdata <= '0;
          endcase
        end
      endcase
    end
  end

  // Sample period timer; saturates until the readout is idle
  assign period_hit = (per_q >= 32'(PERIOD_CYC - 1));
  always_ff @(posedge mclk) begin
    if (!rst_n || !run_q) begin
      per_q <= '0;
    end else if (st_q == hap_pkg::ST_IDLE && period_hit && !cfg_go_q) begin
      per_q <= '0;
    end else if (!period_hit) begin
      per_q <= per_q + 32'h0000_0001; // Holds at the end
    end
  end

  // Z magnitudes and strongest sensor from the 12-bit channels
  always_comb begin
    max_n = '0;
    for (int i = 0; i < NS; i++) begin
      hap_pkg::hap_field_t zf;
      zf = frame_q[i][`HAP_FR_Z];
      absz[i] = zf[11] ? 16'(-$signed(zf)) : 16'(zf);
    end
    for (int i = 1; i < NS; i++) begin
      if (absz[i] > absz[max_n]) begin
        max_n = 2'(i);
      end
    end
    // Keep the old pick unless the new one wins by the margin
    pick_n = max_n;
    if (sel_valid_q && max_n != num_q && absz[num_q] > thresh_q
        && {1'b0, absz[max_n]} < {1'b0, absz[num_q]} + {1'b0, hyst_q}) begin
      pick_n = num_q;
    end
  end

  // Sensor and control sequencing
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= hap_pkg::ST_IDLE;
      tmr_q <= '0;
      rd_tmr_q <= '0;
      sidx_q <= '0;
      cfg_mode_q <= 1'b0;
      cfg_done_q <= 1'b0;
      conv_trigger_n <= 1'b1;
      spi_cs_n <= 4'hF;
      spi_start_q <= 1'b0;
      cordic_start_q <= 1'b0;
      ref_q <= '0;
      for (int i = 0; i < NS; i++) begin
        frame_q[i] <= '0;
      end
    end else begin
      spi_start_q <= 1'b0;
      cordic_start_q <= 1'b0;
      tmr_q <= tmr_q + 32'h0000_0001;
      rd_tmr_q <= rd_tmr_q + 32'h0000_0001;
      unique case (st_q)
        hap_pkg::ST_IDLE: begin
          tmr_q <= '0;
          if (cfg_go_q) begin
            cfg_mode_q <= 1'b1;
            sidx_q <= '0;
            st_q <= hap_pkg::ST_CSGAP;
          end else if (run_q && period_hit) begin
            conv_trigger_n <= 1'b0;
            ref_q <= ref_pos;
            st_q <= hap_pkg::ST_TRIG;
          end
        end
        hap_pkg::ST_TRIG: begin
          if (tmr_q == 32'(`HAP_TRIG_CYC - 1)) begin
            conv_trigger_n <= 1'b1;
            st_q <= hap_pkg::ST_CONV;
          end
        end
        hap_pkg::ST_CONV: begin
          // Covers TRIPLE_SAMPLE_PSEUDO_SIM conversion and sample point
          if (tmr_q == 32'(CONV_WAIT_CYC + `HAP_TRIG_CYC - 1)) begin
            cfg_mode_q <= 1'b0;
            sidx_q <= '0;
            rd_tmr_q <= '0;
            tmr_q <= '0;
            st_q <= hap_pkg::ST_CSGAP;
          end
        end
        hap_pkg::ST_CSGAP: begin
          if (tmr_q >= 32'(`HAP_SCLK_HALF_CYC)) begin
            spi_cs_n <= ~(4'h1 << sidx_q);
            spi_start_q <= 1'b1;
            st_q <= hap_pkg::ST_XFER;
          end
        end
        hap_pkg::ST_XFER: begin
          tmr_q <= '0;
          if (spi_done) begin
            spi_cs_n <= 4'hF;
            if (!cfg_mode_q) begin
              frame_q[sidx_q] <= spi_rx;
            end
            if (sidx_q != 2'(NS - 1)) begin
              sidx_q <= sidx_q + 2'h1;
              st_q <= hap_pkg::ST_CSGAP;
            end else if (cfg_mode_q) begin
              cfg_done_q <= 1'b1;
              st_q <= hap_pkg::ST_IDLE;
            end else begin
              st_q <= hap_pkg::ST_SEL;
            end
          end
        end
        hap_pkg::ST_SEL: begin
          if (absz[max_n] <= thresh_q) begin
            st_q <= hap_pkg::ST_OUT;
          end else begin
            st_q <= hap_pkg::ST_ZCORR;
          end
        end
        hap_pkg::ST_ZCORR: begin
          cordic_start_q <= 1'b1;
          st_q <= hap_pkg::ST_ANGLE;
        end
        hap_pkg::ST_ANGLE: begin
          if (cordic_done) begin
            st_q <= hap_pkg::ST_POS;
          end
        end
        hap_pkg::ST_POS: st_q <= hap_pkg::ST_OUT;
        hap_pkg::ST_OUT: st_q <= hap_pkg::ST_IDLE;
        default: st_q <= hap_pkg::ST_IDLE;
      endcase
    end
  end

  // Selection, Z correction and position arithmetic
  always_comb begin
    hap_pkg::hap_field_t xf;
    xf = frame_q[num_q][`HAP_FR_X];
    xsel = 16'(xf);
  end

  always_ff @(posedge mclk) begin
    logic signed [16:0] zdiff;
    logic signed [33:0] zprod;
    logic signed [47:0] aprod;
    logic signed [31:0] xabs;
    logic signed [47:0] oprod;
    if (!rst_n) begin
      num_q <= '0;
      sel_valid_q <= 1'b0;
      zc_q <= '0;
      pos_calc_q <= '0;
      position <= '0;
      pos_error <= '0;
      out_of_range <= 1'b0;
      sel_code <= '0;
      pos_valid <= 1'b0;
    end else begin
      zdiff = 17'($signed(16'(hap_pkg::hap_field_t'(
        frame_q[num_q][`HAP_FR_Z])))) - 17'($signed(zoff_q[num_q]));
      zprod = 34'(zdiff) * 34'($signed({1'b0, gain_q[num_q]}));
      aprod = 48'(angle) * 48'(HALF_SP);
      xabs = xsel[15] ? 32'(-xsel) : 32'(xsel);
      oprod = 48'(xabs) * 48'({1'b0, offaxis_q});
      pos_valid <= 1'b0;
      if (st_q == hap_pkg::ST_SEL) begin
        sel_valid_q <= (absz[max_n] > thresh_q);
        num_q <= pick_n;
      end
      if (st_q == hap_pkg::ST_ZCORR) begin
        zc_q <= 18'(zprod >>> `HAP_GAIN_FRAC);
      end
      if (st_q == hap_pkg::ST_POS) begin
        pos_calc_q <= 32'(aprod >>> `HAP_ANG_Q_LOG2)
          + 32'(num_q) * 32'(SPACING_UM) - base_q
          + 32'(oprod >>> `HAP_OFFAXIS_FRAC);
      end
      if (st_q == hap_pkg::ST_OUT) begin
        pos_valid <= 1'b1;
        out_of_range <= !sel_valid_q;
        if (sel_valid_q) begin
          position <= pos_calc_q;
          pos_error <= pos_calc_q - ref_q;
          sel_code <= {1'b0, num_q, 1'b1} + 4'h2; // 3,5,7,9
        end else begin
          position <= '0;
          pos_error <= '0;
          sel_code <= '0;
        end
      end
    end
  end

  hap_spi u_spi (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(spi_start_q),
    .tx_word(cfg_mode_q ? cfg_word_q : rd_word_q),
    .miso_s(so2_q),
    .sclk_q(spi_sclk),
    .mosi_q(spi_mosi),
    .busy_q(spi_busy),
    .done_q(spi_done),
    .rx_q(spi_rx)
  );

  // Angle of X over corrected Z, 90 degrees = 2^14
  hap_cordic u_cordic (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(cordic_start_q),
    .x_in(zc_q),
    .y_in(18'(xsel)),
    .angle_q(angle),
    .done_q(cordic_done)
  );
endmodule : hap_top

// ==== test/hap_top_chk.sv ====
// Port checker of the Hall-array position controller
`timescale 1ns/1ps
module hap_chk #(
  parameter int unsigned PERIOD_CYC = 2000,
  parameter int unsigned CONV_WAIT_CYC = 300
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [31:0] ref_pos,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  input wire logic [3:0] spi_cs_n,
  input wire logic conv_trigger_n,
  input wire logic [31:0] position,
  input wire logic [31:0] pos_error,
  input wire logic out_of_range,
  input wire logic [3:0] sel_code,
  input wire logic pos_valid
);
  logic tr_q;
  logic [7:0] low_q;
  logic [31:0] gap_q;
  logic [31:0] ref_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Trigger history; gap saturates so the first frames never look early
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tr_q <= 1'b1;
      low_q <= 8'h00;
      gap_q <= 32'hFFFF_FFFF;
      ref_q <= 32'h0000_0000;
    end else begin
      tr_q <= conv_trigger_n;
      low_q <= conv_trigger_n ? 8'h00 : low_q + 8'h01;
      if (tr_q && !conv_trigger_n) begin
        gap_q <= 32'h0000_0000;
        ref_q <= ref_pos;
      end else if (gap_q != 32'hFFFF_FFFF) begin
        gap_q <= gap_q + 32'h0000_0001;
      end
    end
  end
  a_trig_width: assert property (
    $rose(conv_trigger_n) |-> low_q == 8'h19)
    else $error("trigger pulse width wrong");
  a_trig_period: assert property (
    $fell(conv_trigger_n) |-> gap_q >= PERIOD_CYC - 1)
    else $error("trigger period too short");
  a_read_delay: assert property (
    $fell(&spi_cs_n) |-> gap_q >= CONV_WAIT_CYC + 24)
    else $error("readout started too early");
  a_cs_quiet: assert property (
    $onehot0(~spi_cs_n) && (!conv_trigger_n -> &spi_cs_n))
    else $error("chip selects overlap");
  a_mosi_hold: assert property (
    $rose(spi_sclk) |-> $stable(spi_mosi))
    else $error("serial data moved at sample edge");
  a_range_zero: assert property (
    out_of_range |-> (position | pos_error) == 0)
    else $error("out of range outputs not zero");
  a_sel_code: assert property (
    pos_valid |-> sel_code inside {0, 3, 5, 7, 9}
      && (sel_code == 0) == out_of_range)
    else $error("selection code illegal");
  a_err_diff: assert property (
    pos_valid && !out_of_range |-> pos_error == position - ref_q)
    else $error("position error mismatch");
endmodule : hap_chk
bind hap_top hap_chk #(.PERIOD_CYC(PERIOD_CYC),
  .CONV_WAIT_CYC(CONV_WAIT_CYC)) u_chk (.mclk, .rst_n, .ref_pos,
  .spi_sclk, .spi_mosi, .spi_cs_n, .conv_trigger_n, .position,
  .pos_error, .out_of_range, .sel_code, .pos_valid);

// ==== test/hap_sns_model.sv ====
// Behavioural model of the four Hall sensors on the shared bus
`timescale 1ns/1ps
module hap_sns_model (
  input wire logic mclk,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  input wire logic [3:0] spi_cs_n,
  input wire logic conv_trigger_n,
  input wire logic [95:0] fld,
  output logic miso,
  output logic [63:0] cfg
);
  logic [95:0] smp = '0;
  logic [31:0] sh = '0;
  logic [31:0] rx = '0;
  logic [3:0] cs_q = 4'hF;
  logic sk_q = 1'b0;
  logic tr_q = 1'b1;
  logic idl = 1'b0;
  int n;
  int nq = 0;
  // Sensor picked by its own chip select
  always_comb n = !spi_cs_n[0] ? 0 : !spi_cs_n[1] ? 1 : !spi_cs_n[2] ? 2 : 3;
  // Released line toggles so a stale bit is never mistaken for data
  assign miso = &spi_cs_n ? idl : sh[31];
  // Pin edges seen through mclk
  always @(posedge mclk) begin
    idl <= ~idl;
    tr_q <= conv_trigger_n;
    sk_q <= spi_sclk;
    cs_q <= spi_cs_n;
    // All latch together; mean of two equal X samples is X
    if (tr_q && !conv_trigger_n) smp <= fld;
    if (&cs_q && !(&spi_cs_n)) begin
      nq <= n;
      sh <= {4'h0, smp[n*24 +: 24], 4'h0};
    end else if (sk_q && !spi_sclk) sh <= {sh[30:0], 1'b0};
    if (!sk_q && spi_sclk) rx <= {rx[30:0], spi_mosi};
    // Config register 2h kept per sensor
    if (!(&cs_q) && &spi_cs_n && rx[30:24] == 7'h02)
      cfg[nq*16 +: 16] <= rx[23:8];
  end
endmodule : hap_sns_model

// ==== test/tb_hap_top.sv ====
// Self-checking bench of the Hall-array position controller
`timescale 1ns/1ps
`include "hap_params.svh"
module tb_hap_top;
  logic mclk, rst_n, reg_wr, reg_rd, sensor_serial_out, spi_sclk;
  logic spi_mosi, conv_trigger_n, out_of_range, pos_valid;
  logic [4:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, ref_pos, position, pos_error, rd_v;
  logic [3:0] spi_cs_n, sel_code;
  logic [95:0] fld;
  logic [63:0] cfg;
  int err_total, check_count, cyc;
  // Short period and wait keep the run brief
  hap_top #(.PERIOD_CYC(2000), .CONV_WAIT_CYC(300)) DUT (.mclk, .rst_n,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ref_pos,
    .sensor_serial_out, .spi_sclk, .spi_mosi, .spi_cs_n, .conv_trigger_n,
    .position, .pos_error, .out_of_range, .sel_code, .pos_valid);
  hap_sns_model u_sns (.mclk, .spi_sclk, .spi_mosi, .spi_cs_n,
    .conv_trigger_n, .fld, .miso(sensor_serial_out), .cfg);
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      print_verdict;
    end
  end
  task automatic chk(input string nm, input logic [31:0] g, e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  function automatic logic near(logic [31:0] v, int e);
    return ($signed(v) - e) inside {[-2:2]};
  endfunction : near
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask : rd
  task automatic waitpv;
    int i;
    i = 0;
    do begin
      @(posedge mclk);
      #1 i++;
    end while (pos_valid !== 1'b1 && i < 9000);
    chk("pos_valid", i < 9000, 1);
  endtask : waitpv
  task automatic s_reset;
    #1 chk("cs_n", spi_cs_n, 4'hF);
    chk("trig_n", conv_trigger_n, 1'b1);
    rd(`HAP_RA_CFGWORD);
    chk("cfgword", rd_v[23:8], 16'h0500);
    rd(5'h0C);
    chk("unmapped", rd_v, 0);
  endtask : s_reset
  // Config write must reach every sensor in its own frame
  task automatic s_cfg;
    int i;
    wr(`HAP_RA_CTRL, 32'h0000_0002);
    i = 0;
    do begin
      rd(`HAP_RA_STATUS);
      i++;
    end while (rd_v[2] !== 1'b1 && i < 3000);
    for (int k = 0; k < 4; k++)
      chk("sns_cfg", cfg[k*16 +: 16], 16'h0500);
  endtask : s_cfg
  // Strongest sensor, kept by hysteresis until clearly beaten
  task automatic s_select;
    logic [11:0] z1 [3] = '{12'h064, 12'h41A, 12'h4B0};
    logic [3:0] es [3] = '{4'h7, 4'h7, 4'h5};
    int p;
    fld = {24'h06_4000, 24'h3E_8000, 24'h06_4000, 24'h06_4000};
    wr(`HAP_RA_THRESH, 32'h0000_01F4);
    wr(`HAP_RA_HYST, 32'h0000_0064);
    wr(`HAP_RA_BASE, 32'h0000_03E8);
    wr(`HAP_RA_CTRL, 32'h0000_0001);
    for (int k = 0; k < 3; k++) begin
      fld[47:36] = z1[k];
      repeat (2) waitpv;
      p = (es[k] - 3) / 2 * `HAP_SPACING_UM - 1000;
      chk("sel_code", sel_code, es[k]);
      chk("position", near(position, p), 1);
      chk("pos_error", near(pos_error, p - 40000), 1);
      chk("in_range", out_of_range, 0);
    end
  endtask : s_select
  task automatic s_range;
    fld = {4{24'h06_4000}};
    repeat (2) waitpv;
    chk("oor", out_of_range, 1);
    chk("sel0", sel_code, 0);
    chk("pos0", position | pos_error, 0);
    rd(`HAP_RA_STATUS);
    chk("st_oor", rd_v[1], 1);
  endtask : s_range
  task automatic print_verdict;
    if (err_total == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  initial begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    ref_pos = 32'h0000_9C40;
    fld = '0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    s_reset;
    s_cfg;
    s_select;
    s_range;
    print_verdict;
  end
endmodule : tb_hap_top
